/* hdl/seg_pkg.sv */
// constants shared by both ends of the serial segment link
// assumes one 100 MHz clock and a synchronous active-low reset at each end
// How it works
// RULE1: only data and clock lines carry frames
// RULE2: source sends start one then 35 bits
// RULE3: 36th clock high copies bits to latches
// RULE4: following clock low clears shift stages
// RULE5: clear spares first stage master half
// RULE6: source always sends full 36 clocks
// RULE7: power-on reset clears shifts and latches
// RULE8: start bit plus clock resumes reception
// RULE9: first data bit drives output one
// RULE10: latched one turns segment on
// RULE11: outputs change only when bit differs
// RULE12: enable variant drops 35th output
// RULE13: serial clock no faster than 0.5MHz
// RULE14: shift stages hold bits while idle
// RULE15: inactive enable ignores clock and data; here only rises are gated, so a fall after a load still clears the stages
// RULE16: data sampled on rising clock edge
package seg_pkg;
  localparam int DATA_BITS  = 35;
  localparam int FRAME_BITS = 36;
  localparam int CNT_W      = 6;
  localparam logic [CNT_W-1:0] CNT_LAST = 6'h23;
  localparam int CLK_MHZ    = 100;
  // serial clock ceiling in kHz
  localparam int SCLK_MAX_KHZ = 500;
  // half period of serial clock in system cycles, rounded up
  localparam int HALF_CYC = (CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
  localparam int HALF_W   = 7;
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(HALF_CYC - 1);
  localparam int BUF_DEPTH = 2;
endpackage

/* hdl/seg_link_if.sv */
// two-wire serial link between data source and segment driver
// assumes both ends share the system clock
`timescale 1ns/1ps
interface seg_link_if;
  logic sdata;
  logic sclk;
  modport source (output sdata, output sclk);
  modport driver (input sdata, input sclk);
endinterface

/* hdl/seg_source.sv */
// data source end: buffers frames and shifts them out on the two-wire link
// assumes the driver samples data on the rising serial clock
`timescale 1ns/1ps
module seg_source (
  input  wire logic                         CLK,
  input  wire logic                         NRST,
  input  wire logic [seg_pkg::DATA_BITS-1:0] WORD,
  input  wire logic                         WORD_VALID,
  output logic                              WORD_READY,
  output logic                              BUSY,
  seg_link_if.source                        link
);
  typedef enum logic [1:0] {IDLE, LOW, HIGH} st_t;
  // ************************************************
  // two-entry buffer
  // ************************************************
  logic [seg_pkg::DATA_BITS-1:0] mem_r [seg_pkg::BUF_DEPTH];
  logic [1:0] cnt_r;
  logic       wp_r;
  logic       rp_r;
  wire        buf_valid = (cnt_r != 2'h0);
  wire        pop;
  wire        push = WORD_VALID && WORD_READY;
  assign WORD_READY = (cnt_r != 2'h2);
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cnt_r <= 2'h0;
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= WORD;
        wp_r        <= ~wp_r;
      end
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  // ************************************************
  // serializer
  // ************************************************
  st_t st_r;
  logic [seg_pkg::FRAME_BITS-1:0] sh_r;
  logic [seg_pkg::CNT_W-1:0]      bit_r;
  logic [seg_pkg::HALF_W-1:0]     tm_r;
  logic                           sdata_r;
  logic                           sclk_r;
  wire half_done = (tm_r == seg_pkg::HALF_LAST);
  wire last_bit  = (bit_r == seg_pkg::CNT_LAST);
  assign pop = (st_r == IDLE) && buf_valid;
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st_r    <= IDLE;
      sh_r    <= '0;
      bit_r   <= '0;
      tm_r    <= '0;
      sdata_r <= 1'b0;
      sclk_r  <= 1'b0;
    end else begin
      unique case (st_r)
        IDLE: begin
          if (buf_valid) begin
            // start one, then bit 1 first; data changes only while clock low
            sh_r    <= {mem_r[rp_r], 1'b1}; // RULE2
            bit_r   <= '0;
            tm_r    <= '0;
            st_r    <= LOW;
          end
        end
        LOW: begin
          sdata_r <= sh_r[0]; // RULE16
          tm_r    <= half_done ? '0 : tm_r + 1'b1;
          if (half_done) begin
            sclk_r <= 1'b1;
            st_r   <= HIGH;
          end
        end
        HIGH: begin
          tm_r <= half_done ? '0 : tm_r + 1'b1;
          // half periods keep the link at or under 0.5MHz
          if (half_done) begin // RULE13
            sclk_r <= 1'b0;
            sh_r   <= sh_r >> 1;
            bit_r  <= bit_r + 1'b1;
            // always the full 36 clocks
            st_r   <= last_bit ? IDLE : LOW; // RULE6
          end
        end
      endcase
    end
  end
  assign link.sdata = sdata_r; // RULE1
  assign link.sclk  = sclk_r;
  assign BUSY = (st_r != IDLE);
endmodule // seg_source

/* hdl/seg_driver.sv */
// segment driver end: receives 36-clock frames and drives latched outputs
// assumes serial clock is slow relative to CLK and synchronous to it
`timescale 1ns/1ps
module seg_driver (
  input  wire logic                          CLK,
  input  wire logic                          NRST,
  input  wire logic                          ENABLE_VARIANT,
  input  wire logic                          DATA_EN,
  output logic [seg_pkg::DATA_BITS-1:0]      SEG_ON,
  seg_link_if.driver                         link
);
  // ************************************************
  // edge detection on serial clock
  // ************************************************
  logic sclk_d_r;
  wire  en     = !ENABLE_VARIANT || DATA_EN; // RULE15
  wire  rise   = link.sclk && !sclk_d_r && en;
  wire  fall   = !link.sclk && sclk_d_r;
  always_ff @(posedge CLK) begin
    if (!NRST) sclk_d_r <= 1'b0;
    else       sclk_d_r <= link.sclk;
  end
  // ************************************************
  // shift stages, clear flag and latches
  // ************************************************
  // registers hold value indefinitely when no edge arrives
  logic [seg_pkg::FRAME_BITS-1:0] sh_r; // RULE14
  logic                           clr_pend_r;
  logic [seg_pkg::DATA_BITS-1:0]  lat_r;
  wire  [seg_pkg::FRAME_BITS-1:0] sh_nxt = {link.sdata, sh_r[seg_pkg::FRAME_BITS-1:1]}; // RULE16
  // frame complete when start bit reaches the far stage
  wire  load = rise && sh_r[1]; // RULE3
  wire  [seg_pkg::DATA_BITS-1:0] lat_nxt = sh_nxt[seg_pkg::FRAME_BITS-1:1]; // RULE9
  always_ff @(posedge CLK) begin
    if (!NRST) begin // RULE7
      sh_r       <= '0;
      clr_pend_r <= 1'b0;
      lat_r      <= '0;
    end else begin
      if (rise) begin
        sh_r <= sh_nxt; // RULE8
      end
      if (load) begin
        lat_r      <= lat_nxt; // RULE11
        clr_pend_r <= 1'b1;
      end else if (fall && clr_pend_r) begin
        // master half is the pin itself, sampled only at the next rise;
        // a kept last data bit would walk into stage 1 and fake a load
        sh_r       <= '0; // RULE4 RULE5
        clr_pend_r <= 1'b0;
      end
    end
  end
  // ************************************************
  // outputs
  // ************************************************
  // active high means segment sinking current
  assign SEG_ON[seg_pkg::DATA_BITS-2:0] = lat_r[seg_pkg::DATA_BITS-2:0]; // RULE10
  assign SEG_ON[seg_pkg::DATA_BITS-1]   = lat_r[seg_pkg::DATA_BITS-1] && !ENABLE_VARIANT; // RULE12
endmodule // seg_driver

/* dv/seg_link_sva.sv */
// checks on the two-wire segment link
// assumes one clock, fed from the interface signals
`timescale 1ns/1ps
module seg_link_sva (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic sdata,
  input wire logic sclk
);
  // ****
  // rise count, wraps each frame
  // ****
  logic [5:0] cnt_r;
  always_ff @(posedge CLK) begin
    if (!NRST) cnt_r <= 6'h00;
    else if ($rose(sclk)) cnt_r <= (cnt_r == 6'h23) ? 6'h00 : cnt_r + 6'h01;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  rst_idle_a: assert property (disable iff (1'b0) !NRST |=> !sclk && !sdata)
    else $error("link busy in reset");
  data_hold_a: assert property (sclk |-> $stable(sdata))
    else $error("data moved with clock high");
  fall_hold_a: assert property ($fell(sclk) |-> $stable(sdata))
    else $error("data moved at fall");
  high_len_a: assert property ($rose(sclk) |-> ##100 $fell(sclk))
    else $error("high time off");
  low_len_a: assert property ($fell(sclk) |-> not (##[1:99] $rose(sclk)))
    else $error("low time short");
  start_bit_a: assert property ($rose(sclk) && cnt_r == 6'h00 |-> sdata)
    else $error("no start bit");
  mid_frame_a: assert property ($fell(sclk) && cnt_r != 6'h00 |-> ##100 $rose(sclk))
    else $error("frame cut short");
  rst_quiet_a: assert property ($rose(NRST) |-> !sclk [*8])
    else $error("clock after reset");
  cover property ($rose(sclk) && cnt_r == 6'h23);
  cover property ($fell(sclk) && cnt_r == 6'h00);
  cover property (sclk && !sdata);
endmodule // seg_link_sva

/* dv/serial_led_segment_driver_tb_top.sv */
// bench joining source and driver ends over one link
// assumes the package and link interface are compiled first
`timescale 1ns/1ps
module serial_led_segment_driver_tb_top;
  logic        CLK = 0, NRST = 0, WORD_VALID = 0, WORD_READY, BUSY;
  logic        ENABLE_VARIANT = 0, DATA_EN = 0;
  logic [34:0] WORD = '0, SEG_ON;
  int          fails = 0, samples_checked = 0;
  seg_link_if  lnk ();
  seg_source u_seg_source (.CLK, .NRST, .WORD, .WORD_VALID, .WORD_READY, .BUSY, .link(lnk));
  seg_driver u_seg_driver (.CLK, .NRST, .ENABLE_VARIANT, .DATA_EN, .SEG_ON, .link(lnk));
  seg_link_sva u_seg_link_sva (.CLK, .NRST, .sdata(lnk.sdata), .sclk(lnk.sclk));
  initial forever #5 CLK = ~CLK;
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t outputs %h want %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("fails %0d checks %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bounded wait step; a hang ends the run
  task automatic tick(inout int n);
    @(posedge CLK);
    n++;
    if (n > 30000) begin
      fails++;
      final_report();
    end
  endtask
  task automatic push(input logic [34:0] w);
    int n;
    n = 0;
    @(posedge CLK);
    WORD <= w;
    WORD_VALID <= 1'b1;
    do tick(n); while (WORD_READY !== 1'b1);
    WORD_VALID <= 1'b0;
  endtask
  // idle gap between frames is one cycle, so ask for four
  task automatic settle;
    int n, q;
    n = 0;
    q = 0;
    while (BUSY !== 1'b1) tick(n);
    while (q < 4) begin
      tick(n);
      q = (BUSY === 1'b0) ? q + 1 : 0;
    end
  endtask
  // ****
  // scenarios
  // ****
  task s_frame;
    push(35'h4_0000_0001);
    settle();
    chk(SEG_ON, 35'h4_0000_0001);
    push(35'h2_AAAA_5555);
    settle();
    chk(SEG_ON, 35'h2_AAAA_5555);
  endtask
  // third word fills the buffer while the first is sent
  task s_back2back;
    push(35'h1_0F0F_0F0F);
    push(35'h7_F0F0_F0F1);
    push(35'h0_1234_5679);
    settle();
    chk(SEG_ON, 35'h0_1234_5679);
  endtask
  task s_variant;
    ENABLE_VARIANT <= 1'b1;
    push(35'h5_5555_5555);
    settle();
    chk(SEG_ON, 35'h0_1234_5679);
    DATA_EN <= 1'b1;
    push(35'h7_FFFF_FFFF);
    settle();
    chk(SEG_ON, 35'h3_FFFF_FFFF);
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    chk(SEG_ON, 35'h0_0000_0000);
    s_frame();
    s_back2back();
    s_variant();
    final_report();
  end
endmodule // serial_led_segment_driver_tb_top
